/* File: acc_assertions.sv */
/* Port checker for acc_top: bus answer, control fields, conversion span.
   Bound to every acc_top instance; one clock, async active-low reset. */
`timescale 1ns/100ps
module acc_assertions (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [2:0]  INPUT_CHANNEL_SEL,
  input wire logic        CONVERTER_POWER_ON,
  input wire logic        SAMPLE_HOLD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic [12:0] hold_q;
  // ----------------------------------------
  // Hold span counter
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) hold_q <= '0;
    else         hold_q <= SAMPLE_HOLD ? hold_q + 13'h1 : '0;
  end
  sequence wr_ctrl;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00 && AVS_BYTEENABLE[0];
  endsequence
  sequence rd_ctrl;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00;
  endsequence
  bit_one_zero_a: assert property (rd_ctrl |-> !AVS_READDATA[1])
    else $error("control bit one read as one");
  power_follow_a: assert property (wr_ctrl |=> ##1
    CONVERTER_POWER_ON == $past(AVS_WRITEDATA[0], 2))
    else $error("power output differs from written bit");
  chan_follow_a: assert property (wr_ctrl |=> ##1
    INPUT_CHANNEL_SEL == $past(AVS_WRITEDATA[5:3], 2))
    else $error("channel output differs from written field");
  conv_span_a: assert property ($fell(SAMPLE_HOLD) && CONVERTER_POWER_ON |-> hold_q >= 13'd20 && hold_q <= 13'd6010)
    else $error("conversion span out of range");
  off_stops_a: assert property ($fell(CONVERTER_POWER_ON) |-> ##[0:6] !SAMPLE_HOLD)
    else $error("hold stays after power off");
  go_busy_a: assert property (rd_ctrl and AVS_READDATA[2] |-> SAMPLE_HOLD || $past(SAMPLE_HOLD))
    else $error("go reads one with no conversion");
  go_refused_a: assert property (wr_ctrl and AVS_WRITEDATA[2] && !CONVERTER_POWER_ON && !SAMPLE_HOLD |=> !SAMPLE_HOLD [*3])
    else $error("conversion started while unpowered");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
endmodule

bind acc_top acc_assertions u_chk (.CLK(CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .INPUT_CHANNEL_SEL(INPUT_CHANNEL_SEL),
  .CONVERTER_POWER_ON(CONVERTER_POWER_ON), .SAMPLE_HOLD(SAMPLE_HOLD));

/* File: acc_core_model.sv */
/* Comparator of the converter core, behavioural.
   Assumes the trial code is compared against a held input level. */
`timescale 1ns/100ps
module acc_core_model (
  input wire logic       clk,
  input wire logic       pwr_on,
  input wire logic [9:0] trial,
  input wire logic [9:0] level,
  output logic           comp
);
  logic tog_q = 1'b0;
  always_ff @(posedge clk) tog_q <= ~tog_q;
  // Unpowered core gives junk, not a stale answer
  assign comp = pwr_on ? (level >= trial) : tog_q;
endmodule

/* File: acc_pkg.sv */
/*
  Constants for the converter control block: register map, fields,
  reset values and timing figures.
  Assumes a 125 MHz system clock and an Avalon-MM byte-addressed slave.
*/
package acc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL0  = 4'h0;
  localparam logic [3:0] OFS_PCFG   = 4'h4;
  localparam logic [3:0] OFS_RESH   = 4'h8;
  localparam logic [3:0] OFS_RESL   = 4'hC;
  localparam logic [4:0] OFS_STAT   = 5'h10;
  localparam logic [4:0] OFS_MASK   = 5'h14;
  localparam int         ADDR_W     = 5;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CLKSEL_LSB = 6;
  localparam int CHAN_LSB   = 3;
  localparam int GO_BIT     = 2;
  localparam int PWR_BIT    = 0;
  localparam int PCFG_CS_HI = 6;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] PCFG_RST  = 8'h00;
  localparam logic [7:0] PCFG_MASK = 8'hCF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RES_W        = 10;
  localparam int CONV_PERIODS = 11;
  localparam int CLK_MHZ      = 125;
  localparam real RC_PERIOD_US = 4.0;
  localparam int RC_CYCLES    = int'(RC_PERIOD_US * CLK_MHZ);
  localparam int Q_PHASES     = 4;

  typedef enum logic [1:0] {ST_SAMPLE, ST_CONVERT, ST_SWITCH} acc_state_t;
endpackage

/* File: acc_top.sv */
/*
  Converter control block: control/config registers, conversion clock
  divider, conversion sequencer, result registers and interrupt.
  Assumes a successive-approximation core that takes one bit decision per
  conversion-clock enable on the comparator input, and an analog mux.
*/
`timescale 1ns/100ps

// Overview of operation
// - Three-bit code picks Fosc/2,4,8,16,32,64 or internal RC conversion clock.
// - Channel field bits five to three route analog input n to converter.
// - Writing go starts conversion when powered; bit reads one until hardware clears.
// - Power-on bit zero powers converter; cleared means shut off.
// - Control bit one has no function and reads zero.
// - Each conversion yields an unsigned ten-bit result.
// - Conversion takes eleven conversion-clock periods after acquisition.
// - Result is readable in the cycle right after conversion completes.
// - Converter returns to sampling at the next Q4 phase after conversion, one to four clocks later; a new go is taken only after that phase.
module acc_top (
  input  wire logic                         CLK,
  input  wire logic                         ARST_N,
  input  wire logic [acc_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [31:0]                  AVS_WRITEDATA,
  input  wire logic [3:0]                   AVS_BYTEENABLE,
  output logic      [31:0]                  AVS_READDATA,
  output logic                              AVS_WAITREQUEST,
  input  wire logic                         COMP_IN,
  output logic      [2:0]                   INPUT_CHANNEL_SEL,
  output logic                              CONVERTER_POWER_ON,
  output logic                              SAMPLE_HOLD,
  output logic      [acc_pkg::RES_W-1:0]    DAC_TRIAL,
  output logic                              IRQ
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]                 ctrl_q;
  logic [7:0]                 pcfg_q;
  logic [acc_pkg::RES_W-1:0]  res_q;
  logic [acc_pkg::RES_W-1:0]  sar_q;
  logic [3:0]                 bit_q;
  logic [7:0]                 div_q;
  logic [9:0]                 rc_q;
  logic [1:0]                 qph_q;
  logic [1:0]                 stat_q;
  logic [1:0]                 mask_q;
  logic                       ack_q;
  logic [2:0]                 cmp_sync_q;
  logic                       cmp_q;
  acc_pkg::acc_state_t        state_q;

  logic [2:0]  clk_code;
  logic [7:0]  div_end;
  logic        tick;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_pcfg;
  logic        wr_stat;
  logic        wr_mask;
  logic        go_wr;
  logic        done_ev;
  logic        abort_ev;
  logic [31:0] rd_d;

  // Writes commit at the edge where waitrequest is seen low
  assign wr      = AVS_WRITE & AVS_BYTEENABLE[0] & ack_q;
  assign wr_ctrl = wr && AVS_ADDRESS == acc_pkg::ADDR_W'(acc_pkg::OFS_CTRL0);
  assign wr_pcfg = wr && AVS_ADDRESS == acc_pkg::ADDR_W'(acc_pkg::OFS_PCFG);
  assign wr_stat = wr && AVS_ADDRESS == acc_pkg::OFS_STAT;
  assign wr_mask = wr && AVS_ADDRESS == acc_pkg::OFS_MASK;
  assign go_wr   = wr_ctrl && AVS_WRITEDATA[acc_pkg::GO_BIT];

  // ----------------------------------------------------------------
  // Conversion clock select
  // ----------------------------------------------------------------
  assign clk_code = {pcfg_q[acc_pkg::PCFG_CS_HI], ctrl_q[7:6]};

  always_comb begin
    case (clk_code)
      3'h0:    div_end = 8'h01;
      3'h1:    div_end = 8'h07;
      3'h2:    div_end = 8'h1F;
      3'h4:    div_end = 8'h03;
      3'h5:    div_end = 8'h0F;
      3'h6:    div_end = 8'h3F;
      default: div_end = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      div_q <= 8'h00;
    else if (state_q != acc_pkg::ST_CONVERT)
      div_q <= 8'h00;
    else
      div_q <= (div_q >= div_end) ? 8'h00 : div_q + 8'h01;
  end

  // Internal RC conversion clock stand-in
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      rc_q <= 10'h000;
    else if (state_q != acc_pkg::ST_CONVERT)
      rc_q <= 10'h000;
    else
      rc_q <= (rc_q == 10'(acc_pkg::RC_CYCLES - 1)) ? 10'h000 : rc_q + 10'h001;
  end

  assign tick = (clk_code[1:0] == 2'b11)
              ? (rc_q == 10'(acc_pkg::RC_CYCLES - 1))
              : (div_q >= div_end);

  // ----------------------------------------------------------------
  // Comparator input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_sync_q <= 3'h0;
      cmp_q      <= 1'b0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[1:0], COMP_IN};
      // Change taken once the last two stages agree
      if (cmp_sync_q[2] == cmp_sync_q[1])
        cmp_q <= cmp_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Device clock phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      qph_q <= 2'h0;
    else
      qph_q <= qph_q + 2'h1;
  end

  // ----------------------------------------------------------------
  // Sequencer: one period for sample capture, ten bit trials
  // ----------------------------------------------------------------
  // Each bit decision waits on the comparator synchroniser, about six
  // clocks: conversion clocks faster than that lose bits
  assign done_ev  = state_q == acc_pkg::ST_CONVERT && tick
                    && bit_q == 4'(acc_pkg::CONV_PERIODS - 1);
  assign abort_ev = state_q == acc_pkg::ST_CONVERT && !ctrl_q[acc_pkg::PWR_BIT];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= acc_pkg::ST_SAMPLE;
      bit_q   <= 4'h0;
      sar_q   <= '0;
    end else begin
      case (state_q)
        acc_pkg::ST_SAMPLE: begin
          if (go_wr && ctrl_q[acc_pkg::PWR_BIT]) begin
            state_q <= acc_pkg::ST_CONVERT;
            bit_q   <= 4'h0;
            sar_q   <= '0;
          end
        end
        acc_pkg::ST_CONVERT: begin
          // Power loss abandons the conversion
          if (abort_ev)
            state_q <= acc_pkg::ST_SAMPLE;
          else if (tick) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q != 4'h0)
              sar_q[acc_pkg::RES_W - 32'(bit_q)] <= cmp_q;
            if (done_ev)
              state_q <= acc_pkg::ST_SWITCH;
          end
        end
        acc_pkg::ST_SWITCH: begin
          if (qph_q == 2'(acc_pkg::Q_PHASES - 1))
            state_q <= acc_pkg::ST_SAMPLE;
        end
        default: state_q <= acc_pkg::ST_SAMPLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= acc_pkg::CTRL0_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[7:3]              <= AVS_WRITEDATA[7:3];
        ctrl_q[acc_pkg::PWR_BIT] <= AVS_WRITEDATA[0];
      end
      if (done_ev || abort_ev)
        ctrl_q[acc_pkg::GO_BIT] <= 1'b0;
      else if (go_wr && ctrl_q[acc_pkg::PWR_BIT] && state_q == acc_pkg::ST_SAMPLE)
        ctrl_q[acc_pkg::GO_BIT] <= 1'b1;
      ctrl_q[1] <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      pcfg_q <= acc_pkg::PCFG_RST;
    else if (wr_pcfg)
      pcfg_q <= AVS_WRITEDATA[7:0] & acc_pkg::PCFG_MASK;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      mask_q <= 2'h0;
    else if (wr_mask)
      mask_q <= AVS_WRITEDATA[1:0];
  end

  // ----------------------------------------------------------------
  // Result capture and interrupt status
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      res_q <= '0;
    else if (done_ev)
      res_q <= {sar_q[acc_pkg::RES_W-1:1], cmp_q};
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      stat_q <= 2'h0;
    else begin
      // A set in the same cycle overrides the clear
      if (wr_stat)
        stat_q <= stat_q & ~AVS_WRITEDATA[1:0];
      if (done_ev)
        stat_q[0] <= 1'b1;
      if (abort_ev)
        stat_q[1] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  always_comb begin
    case (AVS_ADDRESS)
      acc_pkg::ADDR_W'(acc_pkg::OFS_CTRL0): rd_d = {24'h0, ctrl_q};
      acc_pkg::ADDR_W'(acc_pkg::OFS_PCFG):  rd_d = {24'h0, pcfg_q};
      acc_pkg::ADDR_W'(acc_pkg::OFS_RESH):  rd_d = {30'h0, res_q[9:8]};
      acc_pkg::ADDR_W'(acc_pkg::OFS_RESL):  rd_d = {24'h0, res_q[7:0]};
      acc_pkg::OFS_STAT:                    rd_d = {30'h0, stat_q};
      acc_pkg::OFS_MASK:                    rd_d = {30'h0, mask_q};
      default:                              rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q        <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      if (AVS_READ && !ack_q)
        AVS_READDATA <= rd_d;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_q);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INPUT_CHANNEL_SEL  <= 3'h0;
      CONVERTER_POWER_ON <= 1'b0;
      SAMPLE_HOLD        <= 1'b0;
      DAC_TRIAL          <= '0;
    end else begin
      INPUT_CHANNEL_SEL  <= ctrl_q[5:3];
      CONVERTER_POWER_ON <= ctrl_q[acc_pkg::PWR_BIT];
      SAMPLE_HOLD        <= state_q == acc_pkg::ST_CONVERT;
      DAC_TRIAL          <= sar_q | (bit_q == 4'h0 ? 10'h000
                            : 10'(10'h200 >> (bit_q - 4'h1)));
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(stat_q & mask_q);
  end

endmodule

/* File: testbench.sv */
/* Self-checking bench for acc_top with comparator model.
   Assumes 125 MHz clock and Avalon-MM register access. */
`timescale 1ns/100ps
module testbench;
  logic clk, arst_n, rd, wr, comp, pwr, hold, irq, waitreq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [2:0] chan;
  logic [9:0] trial, aval;
  int fail_count, n_checks;
  localparam logic [4:0] A_CTL = 5'h00, A_CFG = 5'h04, A_RH = 5'h08;
  localparam logic [4:0] A_RL = 5'h0C, A_ST = 5'h10, A_MK = 5'h14;
  localparam int DIV [8] = '{2, 8, 32, 500, 4, 16, 64, 500};
  always #4 clk = ~clk;
  acc_top dut (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .COMP_IN(comp), .INPUT_CHANNEL_SEL(chan),
    .CONVERTER_POWER_ON(pwr), .SAMPLE_HOLD(hold), .DAC_TRIAL(trial), .IRQ(irq));
  acc_core_model core (.clk(clk), .pwr_on(pwr), .trial(trial), .level(aval), .comp(comp));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0; rd <= 1'b0;
    @(posedge clk);
  endtask
  task wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    // Registered outputs follow one edge after the write commits
    @(posedge clk);
  endtask
  task rdchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task t_irq;
    wr32(A_MK, 32'h0);
    wr32(A_CTL, 32'h01);
    repeat (625) @(posedge clk);
    wr32(A_CTL, 32'h05);
    repeat (200) @(posedge clk);
    chk(32'(irq), 32'h0);
    rdchk(A_ST, 32'h1);
    wr32(A_MK, 32'h1);
    chk(32'(irq), 32'h1);
    wr32(A_ST, 32'h1);
    chk(32'(irq), 32'h0);
  endtask
  task t_conv(input logic [2:0] code);
    logic [9:0] v;
    int n;
    // Short conversion clocks outrun the comparator path: full scale only
    v = (DIV[code] < 8) ? 10'h3FF : 10'(code * 146 + 1);
    aval <= v;
    wr32(A_CFG, {25'h0, code[2], 6'h0});
    wr32(A_CTL, {24'h0, code[1:0], code, 3'b001});
    chk(32'(chan), 32'(code));
    repeat (625) @(posedge clk);
    wr32(A_CTL, {24'h0, code[1:0], code, 3'b101});
    n = 0;
    while (irq !== 1'b1 && n < 7000) begin @(posedge clk); n++; end
    chk(32'(n >= 10 * DIV[code] && n <= 12 * DIV[code] + 8), 32'h1);
    rdchk(A_CTL, {24'h0, code[1:0], code, 3'b001});
    rdchk(A_RH, 32'(v[9:8]));
    rdchk(A_RL, 32'(v[7:0]));
    rdchk(A_ST, 32'h1);
    wr32(A_ST, 32'h1);
  endtask
  task t_abort;
    wr32(A_CFG, 32'h40);
    wr32(A_CTL, 32'h81);
    repeat (625) @(posedge clk);
    wr32(A_CTL, 32'h85);
    repeat (100) @(posedge clk);
    rdchk(A_CTL, 32'h85);
    chk(32'(hold), 32'h1);
    wr32(A_CTL, 32'h80);
    rdchk(A_CTL, 32'h80);
    chk(32'(pwr), 32'h0);
    rdchk(A_ST, 32'h2);
    wr32(A_ST, 32'h3);
    wr32(A_CTL, 32'h04);
    rdchk(A_CTL, 32'h0);
    wr32(A_CTL, 32'hFA);
    rdchk(A_CTL, 32'hF8);
    rdchk(5'h18, 32'h0);
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
  initial begin
    clk = 0; arst_n = 0; rd = 0; wr = 0; addr = '0; wdata = '0; be = 4'hF; aval = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(A_CTL, 32'h0);
    rdchk(A_CFG, 32'h0);
    rdchk(A_MK, 32'h0);
    t_irq;
    for (int c = 0; c < 8; c++) t_conv(3'(c));
    t_abort;
    report_and_stop;
  end
endmodule
